// File: rtl/cdw_params.svh
`ifndef CDW_PARAMS_SVH
`define CDW_PARAMS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define CDW_ADDR_CONTROL 8'h31
`define CDW_ADDR_PDN_START 8'h32
`define CDW_ADDR_PDN_END 8'h33

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CDW_DIVSEL_MSB 2
`define CDW_COUNT_MSB 15
`define CDW_DIVSEL_RESET 3'h0
`define CDW_COUNT_RESET 16'h0000

// ----------------------------------------------------------------
// Divider select codes and ratios
// ----------------------------------------------------------------
`define CDW_DIV2 3'h0
`define CDW_BAD1 3'h1
`define CDW_DIV4 3'h2
`define CDW_DIV6 3'h3
`define CDW_DIV8 3'h4
`define CDW_DIV12 3'h5
`define CDW_BAD6 3'h6
`define CDW_DIV1 3'h7
`define CDW_RATIO2 4'h2
`define CDW_RATIO4 4'h4
`define CDW_RATIO6 4'h6
`define CDW_RATIO8 4'h8
`define CDW_RATIO12 4'hc
`define CDW_RATIO1 4'h1

`endif

// File: rtl/cdw_pkg.sv
`default_nettype none
`include "cdw_params.svh"

package cdw_pkg;

   typedef logic [2:0] divsel_t;
   typedef logic [15:0] count_t;
   typedef logic [3:0] ratio_t;

   typedef enum logic {PULSE_AWAKE, PULSE_ASLEEP} pulse_state_e;

   // Division ratio for a select code; forbidden codes never reach here
   function automatic ratio_t ratio_of(input divsel_t sel);
      case (sel)
         `CDW_DIV2: ratio_of = `CDW_RATIO2;
         `CDW_DIV4: ratio_of = `CDW_RATIO4;
         `CDW_DIV6: ratio_of = `CDW_RATIO6;
         `CDW_DIV8: ratio_of = `CDW_RATIO8;
         `CDW_DIV12: ratio_of = `CDW_RATIO12;
         `CDW_DIV1: ratio_of = `CDW_RATIO1;
         default: ratio_of = `CDW_RATIO2;
      endcase
   endfunction

   // True for the two codes that must never be used
   function automatic logic is_forbidden(input divsel_t sel);
      is_forbidden = (sel == `CDW_BAD1) || (sel == `CDW_BAD6);
   endfunction

endpackage

`default_nettype wire

// File: rtl/clock_divider.sv
`default_nettype none
`include "cdw_params.svh"

module clock_divider
   import cdw_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Towards the window engine
   div_if.divider port_d
);

   // ----------------------------------------------------------------
   // Divide counter
   // ----------------------------------------------------------------
   ratio_t count_reg, count_next;
   logic level_reg, level_next;
   ratio_t ratio;
   logic wrap;

   // Count 0..ratio-1, high for the first half of each output cycle
   always_comb begin
      ratio = ratio_of(port_d.sel);
      wrap = (count_reg >= ratio - 4'h1);
      count_next = wrap ? 4'h0 : count_reg + 4'h1;
      level_next = (count_next < (ratio >> 1));
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= 4'h0;
         level_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         level_reg <= level_next;
      end
   end

   // One tick per divided cycle; every cycle for divide-by-1
   assign port_d.tick = wrap;
   assign port_d.level = level_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_div8_spacing: assert property (
      @(posedge clk) disable iff (!reset_n)
      (port_d.tick && port_d.sel == `CDW_DIV8) |->
         ##1 (!port_d.tick || port_d.sel != `CDW_DIV8) [*7]
         ##1 (port_d.tick || port_d.sel != `CDW_DIV8))
      else $error("divide-by-8 tick spacing wrong");

   chk_div1_every: assert property (
      @(posedge clk) disable iff (!reset_n)
      (port_d.sel == `CDW_DIV1 && $past(port_d.sel) == `CDW_DIV1)
         |-> port_d.tick)
      else $error("divide-by-1 missed a tick");

endmodule

`default_nettype wire

// File: rtl/clock_divider_powerdown_window.sv
`default_nettype none
`include "cdw_params.svh"

module clock_divider_powerdown_window
   import cdw_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port from the serial interface
   input wire logic [7:0] reg_addr,
   input wire logic [23:0] reg_wdata,
   input wire logic reg_write_en,
   output logic [23:0] reg_rdata,
   // Period start from the timing engine
   input wire logic period_restart,
   // Divided clock and power-down outputs
   output logic divided_output_clock,
   output logic divided_tick,
   output logic per_period_sleep_pulse
);

   div_if div_link ();

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   divsel_t divider_select_reg, divider_select_next;
   count_t powerdown_begin_count_reg, powerdown_begin_count_next;
   count_t powerdown_finish_count_reg, powerdown_finish_count_next;
   logic [23:0] rdata_reg, rdata_next;
   logic wr_ctrl, wr_start, wr_end;

   // Write decode; forbidden select codes are ignored
   always_comb begin
      wr_ctrl = reg_write_en && (reg_addr == `CDW_ADDR_CONTROL);
      wr_start = reg_write_en && (reg_addr == `CDW_ADDR_PDN_START);
      wr_end = reg_write_en && (reg_addr == `CDW_ADDR_PDN_END);
      divider_select_next = divider_select_reg;
      if (wr_ctrl &&
          !is_forbidden(reg_wdata[`CDW_DIVSEL_MSB:0])) begin
         divider_select_next = reg_wdata[`CDW_DIVSEL_MSB:0];
      end
      powerdown_begin_count_next = powerdown_begin_count_reg;
      if (wr_start) begin
         powerdown_begin_count_next =
            reg_wdata[`CDW_COUNT_MSB:0];
      end
      powerdown_finish_count_next = powerdown_finish_count_reg;
      if (wr_end) begin
         powerdown_finish_count_next =
            reg_wdata[`CDW_COUNT_MSB:0];
      end
   end

   // Read mux, one cycle of latency; unused bits read zero
   always_comb begin
      case (reg_addr)
         `CDW_ADDR_CONTROL: rdata_next = {21'h000000, divider_select_reg};
         `CDW_ADDR_PDN_START: rdata_next = {8'h00, powerdown_begin_count_reg};
         `CDW_ADDR_PDN_END: rdata_next = {8'h00, powerdown_finish_count_reg};
         default: rdata_next = 24'h000000;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         divider_select_reg <= `CDW_DIVSEL_RESET;
         powerdown_begin_count_reg <= `CDW_COUNT_RESET;
         powerdown_finish_count_reg <= `CDW_COUNT_RESET;
         rdata_reg <= 24'h000000;
      end else begin
         divider_select_reg <= divider_select_next;
         powerdown_begin_count_reg <= powerdown_begin_count_next;
         powerdown_finish_count_reg <= powerdown_finish_count_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // ----------------------------------------------------------------
   // Clock divider
   // ----------------------------------------------------------------
   assign div_link.sel = divider_select_reg;

   clock_divider u_divider (
      .clk(clk),
      .reset_n(reset_n),
      .port_d(div_link.divider)
   );

   // Divide-by-1 passes the input clock straight through
   assign divided_output_clock = (divider_select_reg == `CDW_DIV1) ?
                                 clk : div_link.level;
   assign divided_tick = div_link.tick;

   // ----------------------------------------------------------------
   // Power-down window
   // ----------------------------------------------------------------
   count_t period_count_reg, period_count_next;
   pulse_state_e pulse_state_reg, pulse_state_next;
   logic step;

   // Period count advances once per divided cycle, zero at restart
   always_comb begin
      step = period_restart || div_link.tick;
      period_count_next = period_count_reg;
      if (period_restart) begin
         period_count_next = 16'h0000;
      end else if (div_link.tick) begin
         period_count_next = period_count_reg + 16'h0001;
      end
      pulse_state_next = pulse_state_reg;
      if (step) begin
         // End wins over start so equal counts give no pulse
         if (period_count_next == powerdown_finish_count_reg) begin
            pulse_state_next = PULSE_AWAKE;
         end else if (period_count_next == powerdown_begin_count_reg) begin
            pulse_state_next = PULSE_ASLEEP;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         period_count_reg <= 16'h0000;
         pulse_state_reg <= PULSE_AWAKE;
      end else begin
         period_count_reg <= period_count_next;
         pulse_state_reg <= pulse_state_next;
      end
   end

   assign per_period_sleep_pulse = (pulse_state_reg == PULSE_ASLEEP);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_select_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      (wr_ctrl && !is_forbidden(reg_wdata[2:0]))
         |=> divider_select_reg == $past(reg_wdata[2:0]))
      else $error("divider select not loaded");

   chk_forbidden_code: assert property (
      @(posedge clk) disable iff (!reset_n)
      (wr_ctrl && is_forbidden(reg_wdata[2:0]))
         |=> $stable(divider_select_reg))
      else $error("forbidden select code was taken");

   chk_pulse_rise: assert property (
      @(posedge clk) disable iff (!reset_n)
      $rose(per_period_sleep_pulse)
         |-> period_count_reg == $past(powerdown_begin_count_reg))
      else $error("sleep pulse rose away from start count");

   chk_pulse_fall: assert property (
      @(posedge clk) disable iff (!reset_n)
      $fell(per_period_sleep_pulse)
         |-> period_count_reg == $past(powerdown_finish_count_reg))
      else $error("sleep pulse fell away from end count");

   chk_count_divided: assert property (
      @(posedge clk) disable iff (!reset_n)
      (!div_link.tick && !period_restart) |=> $stable(period_count_reg))
      else $error("period count moved without a divided tick");

   chk_window_enter: assert property (
      @(posedge clk) disable iff (!reset_n)
      (div_link.tick && !period_restart && !wr_start && !wr_end &&
       period_count_reg + 16'h0001 == powerdown_begin_count_reg &&
       powerdown_begin_count_reg != powerdown_finish_count_reg)
         |=> per_period_sleep_pulse)
      else $error("sleep pulse missed its start");

   chk_idle_zero: assert property (
      @(posedge clk) disable iff (!reset_n)
      (powerdown_begin_count_reg == 16'h0000 &&
       powerdown_finish_count_reg == 16'h0000) [*2]
         |-> !per_period_sleep_pulse)
      else $error("sleep pulse with zero window");

   chk_window_leave: assert property (
      @(posedge clk) disable iff (!reset_n)
      (div_link.tick && !period_restart && !wr_end &&
       period_count_reg + 16'h0001 == powerdown_finish_count_reg)
         |=> !per_period_sleep_pulse)
      else $error("sleep pulse missed its end");

   chk_restart_zero: assert property (
      @(posedge clk) disable iff (!reset_n)
      period_restart |=> period_count_reg == 16'h0000)
      else $error("period count not cleared at restart");

   chk_equal_quiet: assert property (
      @(posedge clk) disable iff (!reset_n)
      (powerdown_begin_count_reg == powerdown_finish_count_reg) [*2]
         |-> !$rose(per_period_sleep_pulse))
      else $error("sleep pulse rose with equal counts");

   chk_rdata_upper: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rdata[23:16] == 8'h00)
      else $error("unused read bits not zero");

   chk_select_legal: assert property (
      @(posedge clk) disable iff (!reset_n)
      !is_forbidden(divider_select_reg))
      else $error("forbidden select code held");

endmodule

`default_nettype wire

// File: rtl/div_if.sv
`default_nettype none

interface div_if;
   logic [2:0] sel;
   logic tick;
   logic level;

   modport ctrl (output sel, input tick, input level);
   modport divider (input sel, output tick, output level);
endinterface

`default_nettype wire

// File: sim/clock_source.sv
`default_nettype none

// ----------------------------------------------------------------
// External clock source
// ----------------------------------------------------------------
module clock_source (
   // Clock towards the device
   output logic clk
);
   timeunit 1ns;
   timeprecision 1ps;

   // Equal halves hold the duty cycle at 50 percent
   // The rate suits simulation speed; band limits are the board's
   // Divided rates follow this rate, not the 4 to 6 MHz band
   initial clk = 1'b0;
   always #5 clk = ~clk;
endmodule

`default_nettype wire

// File: sim/tb_clock_divider_powerdown_window.sv
`default_nettype none
`include "cdw_params.svh"

module tb_clock_divider_powerdown_window;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, reset_n, reg_write_en, period_restart;
   logic [7:0] reg_addr;
   logic [23:0] reg_wdata, reg_rdata;
   logic divided_output_clock, divided_tick, per_period_sleep_pulse;
   int miscompares = 0;
   int compares = 0;
   int cyc = 0, last = 0, cnt = 0, high = 0;
   int seed = 32'h95c42afe;
   bit rd_req = 0, meas = 0, have_last = 0, pulse_q = 0;
   logic [23:0] rd_q[$];
   int per_q[$], edge_q[$], hi_q[$];
   logic [2:0] codes[6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
   int ratios[6] = '{2, 4, 6, 8, 12, 1};

   clock_source u_clk (.clk(clk));

   clock_divider_powerdown_window u_dut (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write_en(reg_write_en),
      .reg_rdata(reg_rdata), .period_restart(period_restart),
      .divided_output_clock(divided_output_clock),
      .divided_tick(divided_tick),
      .per_period_sleep_pulse(per_period_sleep_pulse));

   // ----------------------------------------------------------------
   // Compare and report
   // ----------------------------------------------------------------
   task automatic check_word(input logic [23:0] exp, input logic [23:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic check_count(input int exp, input int got, input string w);
      compares++;
      if (got != exp) begin
         miscompares++;
         $display("unexpected at %0t: %s %0d, wanted %0d", $time, w, got, exp);
      end
   endtask

   task automatic final_report;
      miscompares += rd_q.size() + per_q.size() + edge_q.size();
      miscompares += hi_q.size();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Drivers, all changes at the falling edge
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_write_en = 1'b1;
      @(negedge clk);
      reg_write_en = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [23:0] exp);
      @(negedge clk);
      reg_addr = a;
      rd_q.push_back(exp);
      rd_req = 1'b1;
      @(negedge clk);
      rd_req = 1'b0;
   endtask

   task automatic restart;
      @(negedge clk);
      period_restart = 1'b1;
      @(negedge clk);
      period_restart = 1'b0;
   endtask

   // Watcher: tick spacing, clock high time, read data and pulse edges
   always @(posedge clk) begin
      if (divided_tick === 1'b1) begin
         if (meas && have_last) begin
            check_count(per_q.pop_front(), cyc - last, "gap");
            check_count(hi_q.pop_front(), high, "high");
         end
         last = cyc;
         have_last = meas;
         high = 0;
      end
      cyc++;
      if (period_restart === 1'b1) cnt = 0;
      else if (divided_tick === 1'b1) cnt++;
      #1;
      // Output clock samples once per input cycle, just after the edge
      if (divided_output_clock === 1'b1) high++;
      if (rd_req) check_word(rd_q.pop_front(), reg_rdata);
      if (per_period_sleep_pulse !== pulse_q) begin
         if (edge_q.size() == 0) check_count(-1, cnt, "edge");
         else check_count(edge_q.pop_front(), cnt, "edge");
         pulse_q = per_period_sleep_pulse;
      end
   end

   // Watchdog well beyond the expected run
   initial begin
      #100000;
      miscompares++;
      final_report();
   end

   initial begin
      int s, e;
      reset_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 24'h000000;
      reg_write_en = 1'b0;
      period_restart = 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk) reset_n = 1'b1;
      // Reset values and an unmapped place
      rd(`CDW_ADDR_CONTROL, 24'h000000);
      rd(`CDW_ADDR_PDN_START, 24'h000000);
      rd(`CDW_ADDR_PDN_END, 24'h000000);
      rd(8'h34, 24'h000000);
      // Zero counts give no pulse over a period
      restart();
      repeat (40) @(negedge clk);
      // Every legal ratio, measured in input cycles between ticks
      foreach (codes[i]) begin
         wr(`CDW_ADDR_CONTROL, {21'h0, codes[i]});
         rd(`CDW_ADDR_CONTROL, {21'h0, codes[i]});
         repeat (30) @(negedge clk);
         repeat (4) per_q.push_back(ratios[i]);
         repeat (4) hi_q.push_back((ratios[i] + 1) / 2);
         meas = 1;
         for (int k = 0; k < 100 && per_q.size() > 0; k++) @(negedge clk);
         meas = 0;
      end
      // Forbidden codes leave the select alone
      wr(`CDW_ADDR_CONTROL, 24'h000001);
      wr(`CDW_ADDR_CONTROL, 24'h000006);
      rd(`CDW_ADDR_CONTROL, 24'h000007);
      // Window in divided cycles; last round has start equal to end
      wr(`CDW_ADDR_CONTROL, 24'h000000);
      repeat (60) @(negedge clk);
      for (int k = 0; k < 3; k++) begin
         s = 2 + (($random(seed) & 32'h7fffffff) % 20);
         e = (k < 2) ? s + 1 + (($random(seed) & 32'h7fffffff) % 10) : s;
         wr(`CDW_ADDR_PDN_START, {8'h00, s[15:0]});
         wr(`CDW_ADDR_PDN_END, {8'h00, e[15:0]});
         rd(`CDW_ADDR_PDN_START, {8'h00, s[15:0]});
         rd(`CDW_ADDR_PDN_END, {8'h00, e[15:0]});
         if (e != s) begin
            repeat (2) begin
               edge_q.push_back(s);
               edge_q.push_back(e);
            end
         end
         repeat (2) begin
            restart();
            repeat (100) @(negedge clk);
         end
      end
      final_report();
   end
endmodule

`default_nettype wire
